// ==== core/bec_params.svh ====
`ifndef BEC_PARAMS_SVH
`define BEC_PARAMS_SVH
// data space map
`define BEC_ADDR_BANK_SEL     8'hE8
`define BEC_ADDR_EE_CTRL      8'hEA
`define BEC_WIN_LO            8'h00
`define BEC_WIN_HI            8'h3F
`define BEC_DIRECT_LO         8'h80
`define BEC_DIRECT_HI         8'hBF
// bank select codes
`define BEC_BANK_EE0          8'h01
`define BEC_BANK_EE1          8'h02
`define BEC_BANK_EE2          8'h03
`define BEC_BANK_EE3          8'h81
`define BEC_BANK_EE4          8'h82
`define BEC_BANK_EE5          8'h83
`define BEC_BANK_RAM2         8'h04
`define BEC_BANK_RAM3         8'h08
`define BEC_BANK_RAM4         8'h10
`define BEC_BANK_OSD5         8'h20
`define BEC_BANK_OSD6         8'h40
// control bit positions
`define BEC_CTL_EN            0
`define BEC_CTL_BS            1
`define BEC_CTL_PE            2
`define BEC_CTL_PS            3
`define BEC_CTL_SB            6
`define BEC_CTL_RESET         8'h00
// write time: average 5 ms, at most 10 ms
`define BEC_WRITE_TIME_MS     5
`define BEC_CLK_HZ            10000000
`define BEC_WRITE_CYCLES      (`BEC_WRITE_TIME_MS * (`BEC_CLK_HZ / 1000))
`endif

// ==== core/bec_pkg.sv ====
package bec_pkg;
   typedef enum logic [2:0] {
      BEC_IDLE  = 3'b001,
      BEC_BYTE  = 3'b010,
      BEC_ROW   = 3'b100
   } bec_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bec_bus_t;

   typedef struct packed {
      logic       standby;
      logic       row_program_start;
      logic       row_program_enable;
      logic       write_enable;
   } bec_ctl_t;
endpackage : bec_pkg

// ==== core/bec_timer.sv ====
`timescale 1ns/1ps
`include "bec_params.svh"
module bec_timer #(
   parameter int CYCLES = 50000
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic start,
   output logic      done
);
   initial begin
      if (CYCLES < 2) $error("bec_timer: CYCLES too small");
   end
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count;
   logic         running;
   wire          last = running && (count == W'(CYCLES - 1));
   always_ff @(posedge clk) begin
      if (!rstn) begin
         count   <= '0;
         running <= 1'b0;
      end else if (start) begin
         count   <= '0;
         running <= 1'b1;
      end else if (running) begin
         count   <= last ? '0 : count + W'(1);
         running <= !last;
      end
   end
   assign done = last;
endmodule : bec_timer

// ==== core/bec_row_buf.sv ====
`timescale 1ns/1ps
module bec_row_buf #(
   parameter int DEPTH = 8
) (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire logic                     clear,
   input  wire logic                     wr,
   input  wire logic [$clog2(DEPTH)-1:0] idx,
   input  wire logic [7:0]               wdata,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [7:0]               rdata,
   output logic      [DEPTH-1:0]         loaded
);
   initial begin
      if (DEPTH != 8) $error("bec_row_buf: row is eight bytes");
   end
   logic [7:0] data [DEPTH];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_lat
         wire hit = wr && (idx == ($clog2(DEPTH))'(g));
         always_ff @(posedge clk) begin
            if (!rstn || clear) begin
               data[g]   <= 8'h00;
               loaded[g] <= 1'b0;
            end else if (hit) begin
               data[g]   <= wdata;
               loaded[g] <= 1'b1;
            end
         end
      end
   endgenerate
   assign rdata = data[rd_idx];
endmodule : bec_row_buf

// ==== core/bec_ctrl.sv ====
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "bec_params.svh"
module bec_ctrl #(
   parameter int EE_BYTES     = 384,
   parameter int WRITE_CYCLES = `BEC_WRITE_CYCLES
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire bec_pkg::bec_bus_t bus,
   output logic      [7:0]   rdata,
   output logic              win_ram_sel,
   output logic      [2:0]   win_ram_page,
   output logic              win_osd_sel,
   output logic              win_osd_page6,
   output logic              direct_ram_sel,
   output logic              eeprom_busy_flag,
   output logic              eeprom_standby
);
   initial begin
      if (EE_BYTES != 384) $error("bec_ctrl: six 64-byte pages only");
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]          data_bank_select;
   bec_pkg::bec_ctl_t   ctl;
   bec_pkg::bec_state_t state;
   logic [7:0]          ee_mem [EE_BYTES];
   logic [8:0]          byte_addr;
   logic [7:0]          byte_data;
   logic                row_latched;
   logic [5:0]          row_addr;
   logic [7:0]          rdata_q;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire [7:0] a          = bus.addr;
   wire       in_window  = (a >= `BEC_WIN_LO) && (a <= `BEC_WIN_HI);
   assign direct_ram_sel = (a >= `BEC_DIRECT_LO) && (a <= `BEC_DIRECT_HI);

   wire       ee_code    = (data_bank_select[6:2] == 5'b00000)
                           && (data_bank_select[1:0] != 2'b00);
   wire [2:0] ee_page    = {1'b0, data_bank_select[1:0]} - 3'd1
                           + (data_bank_select[7] ? 3'd3 : 3'd0);
   wire       ee_sel     = in_window && ee_code;
   assign win_ram_sel    = in_window && (data_bank_select[4:2] != 3'b000);
   assign win_ram_page   = data_bank_select[2] ? 3'd2 :
                           data_bank_select[3] ? 3'd3 : 3'd4;
   assign win_osd_sel    = in_window && (data_bank_select[6:5] != 2'b00);
   assign win_osd_page6  = data_bank_select[6];

   wire [8:0] ee_addr    = 9'({ee_page, a[5:0]});
   wire       busy       = (state != bec_pkg::BEC_IDLE);
   wire       wr_bank    = bus.wr && (a == `BEC_ADDR_BANK_SEL);
   wire       wr_ctl     = bus.wr && (a == `BEC_ADDR_EE_CTRL);
   wire       rd_ctl     = bus.rd && (a == `BEC_ADDR_EE_CTRL);
   // busy aborts eeprom access; standby blocks it
   wire       ee_ok      = ee_sel && !busy && !ctl.standby;
   wire       ee_wr      = bus.wr && ee_ok && ctl.write_enable;
   wire       row_mode   = ctl.row_program_enable;
   wire       row_match  = !row_latched || (ee_addr[8:3] == row_addr);
   wire       byte_go    = ee_wr && !row_mode;
   // row bytes go to volatile latches
   wire       row_wr     = ee_wr && row_mode && row_match;

   wire       ctl_take   = wr_ctl && !busy;
   wire       new_en     = bus.wdata[`BEC_CTL_EN];
   wire       new_pe     = bus.wdata[`BEC_CTL_PE];
   wire       pe_rise    = ctl_take && new_pe && !ctl.row_program_enable;
   // start only with enable and row enable
   wire       ps_go      = ctl_take && bus.wdata[`BEC_CTL_PS]
                           && new_en && new_pe;
   wire       timer_start = byte_go || ps_go;
   wire       timer_done;

   // ------------------------------------------------------------
   // write timer and row latches
   // ------------------------------------------------------------
   // program time count
   bec_timer #(
      .CYCLES (WRITE_CYCLES)
   ) u_timer (
      .clk   (clk),
      .rstn  (rstn),
      .start (timer_start),
      .done  (timer_done)
   );

   logic [7:0] row_rdata;
   logic [7:0] row_loaded;
   logic [2:0] prog_idx;
   bec_row_buf #(
      .DEPTH (8)
   ) u_row (
      .clk    (clk),
      .rstn   (rstn),
      .clear  (pe_rise),
      .wr     (row_wr),
      .idx    (ee_addr[2:0]),
      .wdata  (bus.wdata),
      .rd_idx (prog_idx),
      .rdata  (row_rdata),
      .loaded (row_loaded)
   );

   // ------------------------------------------------------------
   // bank select register
   // ------------------------------------------------------------
   // bank select write-only, no reset value
   always_ff @(posedge clk) begin
      if (wr_bank) begin
         data_bank_select <= bus.wdata;
      end
   end

   // ------------------------------------------------------------
   // control register and sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctl         <= bec_pkg::bec_ctl_t'(4'h0);
         state       <= bec_pkg::BEC_IDLE;
         row_latched <= 1'b0;
         row_addr    <= 6'h00;
         byte_addr   <= 9'h000;
         byte_data   <= 8'h00;
      end else begin
         case (state)
            bec_pkg::BEC_IDLE: begin
               if (ctl_take) begin
                  ctl.standby            <= bus.wdata[`BEC_CTL_SB];
                  ctl.write_enable       <= new_en;
                  ctl.row_program_enable <= new_pe;
                  ctl.row_program_start  <= ps_go;
                  if (!new_pe) begin
                     row_latched <= 1'b0;
                  end
               end
               if (row_wr && !row_latched) begin
                  row_latched <= 1'b1;
                  row_addr    <= ee_addr[8:3];
               end
               if (byte_go) begin
                  state     <= bec_pkg::BEC_BYTE;
                  byte_addr <= ee_addr;
                  byte_data <= bus.wdata;
               end else if (ps_go) begin
                  state <= bec_pkg::BEC_ROW;
               end
            end
            bec_pkg::BEC_BYTE: begin
               if (timer_done) begin
                  state <= bec_pkg::BEC_IDLE;
               end
            end
            bec_pkg::BEC_ROW: begin
               // end of row clears row bits
               if (timer_done) begin
                  state                  <= bec_pkg::BEC_IDLE;
                  ctl.row_program_enable <= 1'b0;
                  ctl.row_program_start  <= 1'b0;
                  row_latched            <= 1'b0;
               end
            end
            default: begin
               state <= bec_pkg::BEC_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // eeprom array commit
   // ------------------------------------------------------------
   // row copy walks the latches one per cycle during programming
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prog_idx <= 3'd0;
      end else if (state == bec_pkg::BEC_ROW) begin
         prog_idx <= prog_idx + 3'd1;
      end else begin
         prog_idx <= 3'd0;
      end
   end

   wire [8:0] row_cell = {row_addr, prog_idx};
   wire       row_commit = (state == bec_pkg::BEC_ROW)
                           && row_loaded[prog_idx];
   wire       byte_commit = (state == bec_pkg::BEC_BYTE) && timer_done;

   // array contents are not reset: nonvolatile
   always_ff @(posedge clk) begin
      if (byte_commit) begin
         ee_mem[byte_addr] <= byte_data;
      end else if (row_commit) begin
         ee_mem[row_cell] <= row_rdata;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // only busy is readable from control
   wire [7:0] ctl_rd   = {6'b00_0000, busy, 1'b0};
   wire       ee_rd    = bus.rd && ee_ok;
   wire [7:0] next_rd  = rd_ctl ? ctl_rd :
                         ee_rd  ? ee_mem[ee_addr] : 8'h00;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= next_rd;
      end
   end

   assign rdata            = rdata_q;
   assign eeprom_busy_flag = busy;
   assign eeprom_standby   = ctl.standby;
endmodule : bec_ctrl

// ==== testbench/bec_ctrl_chk.sv ====
`timescale 1ns/1ps
module bec_ctrl_chk #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire bec_pkg::bec_bus_t bus,
   input wire logic [7:0]        rdata,
   input wire logic              win_ram_sel,
   input wire logic [2:0]        win_ram_page,
   input wire logic              win_osd_sel,
   input wire logic              win_osd_page6,
   input wire logic              direct_ram_sel,
   input wire logic              eeprom_busy_flag,
   input wire logic              eeprom_standby
);
   // ----------
   // properties
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // counts busy cycles, so the write time is bounded on both sides
   int busy_cnt;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= eeprom_busy_flag ? busy_cnt + 1 : 0;
      end
   end
   sequence s_ee_read;
      bus.rd && bus.addr < 8'h40 && !win_ram_sel && !win_osd_sel;
   endsequence
   sequence s_ctl_read;
      bus.rd && bus.addr == 8'hEA;
   endsequence
   a_direct_map: assert property (
      direct_ram_sel == (bus.addr[7:6] == 2'b10))
      else $error("direct select wrong");
   a_window_only: assert property (
      (win_ram_sel || win_osd_sel) |-> bus.addr < 8'h40)
      else $error("page select outside window");
   a_ram_page: assert property (
      win_ram_sel |-> win_ram_page inside {3'h2, 3'h3, 3'h4})
      else $error("bad ram page");
   a_busy_cause: assert property (
      $rose(eeprom_busy_flag) |-> $past(bus.wr))
      else $error("busy rose without write");
   a_busy_hold: assert property (
      $rose(eeprom_busy_flag) |-> eeprom_busy_flag[*8])
      else $error("busy too short");
   a_busy_bound: assert property (
      busy_cnt <= WRITE_CYCLES + 1)
      else $error("busy too long");
   a_busy_length: assert property (
      $fell(eeprom_busy_flag) |-> busy_cnt >= WRITE_CYCLES - 1)
      else $error("write ended early");
   a_ctl_read: assert property (
      s_ctl_read |=> rdata == {6'h00, $past(eeprom_busy_flag), 1'b0})
      else $error("control read wrong");
   a_busy_abort: assert property (
      eeprom_busy_flag ##0 s_ee_read |=> rdata == 8'h00)
      else $error("read not aborted while busy");
   a_standby_read: assert property (
      eeprom_standby ##0 s_ee_read |=> rdata == 8'h00)
      else $error("read served in standby");
   a_reset_clear: assert property (
      $rose(rstn) |-> !eeprom_busy_flag && !eeprom_standby)
      else $error("control not cleared by reset");
endmodule : bec_ctrl_chk

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
   mismatches++; $display("Error %0t: got %h want %h", $time, a, e); end end
module tb_top;
   // -----
   // bench
   // -----
   logic              clk;
   logic              rstn;
   bec_pkg::bec_bus_t bus;
   logic [7:0]        rdata;
   logic              win_ram_sel;
   logic [2:0]        win_ram_page;
   logic              win_osd_sel;
   logic              win_osd_page6;
   logic              direct_ram_sel;
   logic              eeprom_busy_flag;
   logic              eeprom_standby;
   logic [7:0]        got;
   int                mismatches;
   int                checks_done;
   // bank code, ram sel, ram page, osd sel, page six
   logic [15:0] rows [11] = '{16'h04A0, 16'h08B0, 16'h10C0, 16'h2008,
      16'h4009, 16'h0100, 16'h0200, 16'h0300, 16'h8100, 16'h8200, 16'h8300};
   logic [7:0]  pg [6] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83};
   // address, expected byte after the row program
   logic [15:0] rb [4] = '{16'h1811, 16'h1A22, 16'h1B33, 16'h05A0};
   bec_ctrl #(.WRITE_CYCLES(20)) dut_u (.clk, .rstn, .bus, .rdata,
      .win_ram_sel, .win_ram_page, .win_osd_sel, .win_osd_page6,
      .direct_ram_sel, .eeprom_busy_flag, .eeprom_standby);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic give_verdict;
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // one bus cycle, strobe released on the next edge; read data kept
   task automatic op(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1 got = rdata;
   endtask : op
   task automatic wait_idle;
      for (int i = 0; i < 200 && eeprom_busy_flag; i++) begin
         @(posedge clk);
         #1;
      end
      if (eeprom_busy_flag) begin
         mismatches++;
         give_verdict();
      end
   endtask : wait_idle
   initial begin
      rstn = 1'b0;
      bus = '0;
      mismatches = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      op(8'hEA, 8'h00, 1'b0);
      `CHK(got, 8'h00)
      `CHK({eeprom_busy_flag, eeprom_standby}, 2'b00)
      op(8'h90, 8'h00, 1'b0);
      `CHK(direct_ram_sel, 1'b1)
      op(8'hC0, 8'h00, 1'b0);
      `CHK({direct_ram_sel, got}, 9'h000)
      foreach (rows[i]) begin
         op(8'hE8, rows[i][15:8], 1'b1);
         op(8'h10, 8'h00, 1'b0);
         `CHK({win_ram_sel, win_osd_sel}, {rows[i][7], rows[i][3]})
         if (rows[i][7]) `CHK(win_ram_page, rows[i][6:4])
         if (rows[i][3]) `CHK(win_osd_page6, rows[i][0])
      end
      op(8'hEA, 8'h01, 1'b1);
      // a control write during busy must not drop the enable bit
      foreach (pg[p]) begin
         op(8'hE8, pg[p], 1'b1);
         op(8'h05, 8'(8'hA0 + p), 1'b1);
         `CHK(eeprom_busy_flag, 1'b1)
         op(8'hEA, 8'h00, 1'b1);
         op(8'hEA, 8'h00, 1'b0);
         `CHK(got, 8'h02)
         op(8'h05, 8'h00, 1'b0);
         `CHK(got, 8'h00)
         wait_idle();
      end
      foreach (pg[p]) begin
         op(8'hE8, pg[p], 1'b1);
         op(8'h05, 8'h00, 1'b0);
         `CHK(got, 8'(8'hA0 + p))
      end
      op(8'hE8, 8'h01, 1'b1);
      op(8'hEA, 8'h00, 1'b1);
      op(8'h05, 8'h55, 1'b1);
      `CHK(eeprom_busy_flag, 1'b0)
      op(8'hEA, 8'h0C, 1'b1);
      `CHK(eeprom_busy_flag, 1'b0)
      op(8'hEA, 8'h05, 1'b1);
      op(8'h18, 8'h11, 1'b1);
      op(8'h1A, 8'h22, 1'b1);
      `CHK(eeprom_busy_flag, 1'b0)
      op(8'h1B, 8'h33, 1'b1);
      op(8'h05, 8'h77, 1'b1);
      op(8'hEA, 8'h0D, 1'b1);
      `CHK(eeprom_busy_flag, 1'b1)
      wait_idle();
      foreach (rb[i]) begin
         op(rb[i][15:8], 8'h00, 1'b0);
         `CHK(got, rb[i][7:0])
      end
      op(8'hEA, 8'h09, 1'b1);
      `CHK(eeprom_busy_flag, 1'b0)
      op(8'hEA, 8'h05, 1'b1);
      op(8'h18, 8'h44, 1'b1);
      op(8'hEA, 8'h01, 1'b1);
      op(8'hEA, 8'h09, 1'b1);
      op(8'h18, 8'h00, 1'b0);
      `CHK({eeprom_busy_flag, got}, 9'h011)
      op(8'hEA, 8'h40, 1'b1);
      `CHK(eeprom_standby, 1'b1)
      op(8'h18, 8'h00, 1'b0);
      `CHK(got, 8'h00)
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CHK(eeprom_standby, 1'b0)
      give_verdict();
   end
endmodule : tb_top
bind bec_ctrl bec_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.clk,
   .rstn, .bus, .rdata, .win_ram_sel, .win_ram_page, .win_osd_sel,
   .win_osd_page6, .direct_ram_sel, .eeprom_busy_flag, .eeprom_standby);
